// ===== rtl/dagmc_regs.vh
// Register offsets, field positions, reset values and op codes of the address generator
`ifndef DAGMC_REGS_VH
`define DAGMC_REGS_VH
// ****************************************
// Register word addresses (7-bit port)
// ****************************************
`define DAGMC_IDX_BASE 7'h00
`define DAGMC_MOD_BASE 7'h10
`define DAGMC_BUF_BASE 7'h20
`define DAGMC_LEN_BASE 7'h30
`define DAGMC_MODE_ADDR 7'h40
`define DAGMC_STKY_ADDR 7'h41
// ****************************************
// Primary mode word fields
// ****************************************
`define DAGMC_BR_GEN2_BIT 0
`define DAGMC_BR_GEN1_BIT 1
`define DAGMC_LOCK_GEN1_BIT 16
`define DAGMC_LOCK_GEN2_BIT 17
`define DAGMC_MASK_GEN1_BIT 18
`define DAGMC_MASK_GEN2_BIT 19
`define DAGMC_CIRC_EN_BIT 24
`define DAGMC_MODE_RST 32'h00000000
// ****************************************
// Sticky status word fields
// ****************************************
`define DAGMC_OVF_GEN1_BIT 0
`define DAGMC_OVF_GEN2_BIT 1
`define DAGMC_STKY_RST 2'h0
// ****************************************
// Operation codes and word sizes
// ****************************************
`define DAGMC_OP_PRE 3'h0
`define DAGMC_OP_POST 3'h1
`define DAGMC_OP_MODIFY 3'h2
`define DAGMC_OP_REVERSE_BITS_INSTRUCTION 3'h3
`define DAGMC_OP_BRANCH 3'h4
`define DAGMC_SZ_SHORT 2'h0
`define DAGMC_SZ_NORMAL 2'h1
`define DAGMC_SZ_LONG 2'h2
`define DAGMC_OVF_IDX 3'h7
`define DAGMC_BR_IDX 3'h0
`endif

// ===== rtl/dagmc_core.v
// Two data address generators with index cache, stalls and circular overflow
//
// Contract
// - Pre-modify outputs index plus modifier, index left unchanged.
// - Post-modify outputs index, then writes index plus modifier back.
// - Modify registers only pair with index registers of the same generator.
// - Single access takes a full 32-bit immediate modifier.
// - Multifunction access limits the immediate modifier to 6 bits.
// - Output address is scaled by word size for direct memory use.
// - One 32-bit cache entry per generator records and replays pre-modify index.
// - Pre-modify miss costs two cycles, hit costs one.
// - Pre-modify with another index replaces the entry when unlocked, two cycles.
// - Pre-modify with modify register always two cycles and records index.
// - Any write to the cached index invalidates the entry.
// - Lock bit pins the entry; other indexes take two cycles.
// - Write to locked index invalidates data but keeps its identity.
// - Second generator indirect branches bypass cache, untouched, two cycles.
// - Register written just before use inserts a one-cycle stall.
// - Annulled conditional post-modify followed by same index stalls once.
// - Wrap on overflow index sets that generator's sticky flag.
// - Overflow raises a masked interrupt request.
// - Overflow flag stays set after the wrap.
// - Bit-reverse mode reverses output address; post-modify adds normally.
// - Bit-reverse instruction reverses index register contents in place.
// - Bit reversal only on the first index of each generator, never stored.
// - Circular wrap subtracts or adds the length before write-back.
//
// Timing summary: a taken operation costs base plus hazard cycles.
// Base is one for an uncached or register-modified pre-modify access
// and for a second-generator branch; hazard is one after a register
// write or an annulled post-modify that touches the same registers.
// Stall stays high for the cost, then the address strobe pulses once if the operation emits an address.
// The cache only ever replays index values, never modifiers.
//
// Our own choices: the address-and-strobe port and the address map.
`include "dagmc_regs.vh"
module dagmc_core (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Register port
	input wire [6:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	// Operation from decoder
	input wire op_valid_i,
	input wire [2:0] op_kind_i,
	input wire [3:0] op_idx_i,
	input wire [2:0] op_mod_i,
	input wire op_imm_sel_i,
	input wire op_multi_i,
	input wire [31:0] op_imm_i,
	input wire [1:0] op_size_i,
	input wire op_cond_false_i,
	// Address toward memory and status
	output reg [31:0] addr_o,
	output reg addr_valid_o,
	output reg stall_o,
	output reg ovf_irq_o
);

	// ****************************************
	// Helper functions
	// ****************************************
	// Mirror all 32 bits
	function [31:0] bit_rev;
		input [31:0] v;
		integer k;
		begin
			for (k = 0; k < 32; k = k + 1) begin
				bit_rev[k] = v[31 - k];
			end
		end
	endfunction

	// Scale address to word size
	function [31:0] size_adj;
		input [31:0] a;
		input [1:0] sz;
		begin
			case (sz)
				`DAGMC_SZ_SHORT: size_adj = {a[30:0], 1'b0};
				`DAGMC_SZ_LONG: size_adj = {1'b0, a[31:1]};
				default: size_adj = a;
			endcase
		end
	endfunction

	// Match a registered bus address against one register of a bank
	function reg_hit;
		input [6:0] a;
		input [6:0] base;
		input [3:0] idx;
		begin
			reg_hit = a == (base | {3'h0, idx});
		end
	endfunction

	// Bus write that changes one index register, directly or via its base
	function bus_idx_wr;
		input wr;
		input [6:0] a;
		input [3:0] idx;
		begin
			bus_idx_wr = wr & (a[3:0] == idx) & ((a[6:4] == 3'h0) | (a[6:4] == 3'h2));
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg [31:0] idx_mem [0:15];
	reg [31:0] mod_mem [0:15];
	reg [31:0] base_mem [0:15];
	reg [31:0] len_mem [0:15];
	reg [31:0] mode_ff;
	reg [1:0] stky_ff;
	// Cache contents, driven from the per-generator blocks
	wire [2:0] cache_idx [0:1];
	wire [31:0] cache_val [0:1];
	wire [1:0] cache_vld;
	reg [1:0] cnt_ff;
	reg emit_ff;
	reg [31:0] pend_addr_ff;
	reg wr_prev_ff;
	reg [6:0] wr_addr_prev_ff;
	reg annul_ff;
	reg [3:0] annul_idx_ff;

	// ****************************************
	// Operation decode
	// ****************************************
	// Handshake: an operation is taken only while no stall runs
	wire accept = op_valid_i & ~stall_o;
	wire do_op = accept & ~op_cond_false_i;

	// Register selection within the addressed generator
	wire gen = op_idx_i[3];
	wire [3:0] mod_sel = {gen, op_mod_i};
	wire [31:0] i_val = idx_mem[op_idx_i];
	wire [31:0] b_val = base_mem[op_idx_i];
	wire [31:0] l_val = len_mem[op_idx_i];

	// Modifier: immediate, narrow in multifunction form, or register
	wire [31:0] imm6 = {{26{op_imm_i[5]}}, op_imm_i[5:0]};
	wire [31:0] imm_val = op_multi_i ? imm6 : op_imm_i;
	wire [31:0] m_val = op_imm_sel_i ? imm_val : mod_mem[mod_sel];

	// Operation kind
	wire is_pre = op_kind_i == `DAGMC_OP_PRE;
	wire is_post = op_kind_i == `DAGMC_OP_POST;
	wire is_mody = op_kind_i == `DAGMC_OP_MODIFY;
	wire is_brv = op_kind_i == `DAGMC_OP_REVERSE_BITS_INSTRUCTION;
	wire is_br = op_kind_i == `DAGMC_OP_BRANCH;

	// Cache lookup and per-generator mode bits
	wire hit = cache_vld[gen] & (cache_idx[gen] == op_idx_i[2:0]);
	wire lock = gen ? mode_ff[`DAGMC_LOCK_GEN2_BIT] : mode_ff[`DAGMC_LOCK_GEN1_BIT];
	wire brv_en = gen ? mode_ff[`DAGMC_BR_GEN2_BIT] : mode_ff[`DAGMC_BR_GEN1_BIT];

	// Pre-modify base: cached copy on hit
	wire [31:0] pre_base = (is_pre & hit) ? cache_val[gen] : i_val;
	wire [31:0] pre_sum = pre_base + m_val;

	// Circular post-modify with wraparound
	wire circ = mode_ff[`DAGMC_CIRC_EN_BIT] & (l_val != 32'h00000000);
	wire [31:0] sum = i_val + m_val;
	wire [31:0] buf_end = b_val + l_val;
	wire wrap_hi = circ & ~m_val[31] & (sum >= buf_end);
	wire wrap_lo = circ & m_val[31] & (sum < b_val);
	reg [31:0] new_idx;
	always @* begin
		// Write-back value for post, modify and reverse ops
		if (is_brv) begin
			new_idx = bit_rev(i_val);
		end else if (wrap_hi) begin
			new_idx = sum - l_val;
		end else if (wrap_lo) begin
			new_idx = sum + l_val;
		end else begin
			new_idx = sum;
		end
	end
	wire upd_we = do_op & (is_post | is_mody | is_brv);
	wire wrap = do_op & (is_post | is_mody) & (wrap_hi | wrap_lo);
	wire ovf_ev = wrap & (op_idx_i[2:0] == `DAGMC_OVF_IDX);

	// Raw address, bit reversed on the first index of a generator
	wire [31:0] raw_addr = (is_pre | is_br) ? pre_sum : i_val;
	wire brv_hit = brv_en & (op_idx_i[2:0] == `DAGMC_BR_IDX);
	wire [31:0] out_addr = size_adj(brv_hit ? bit_rev(raw_addr) : raw_addr, op_size_i);

	// ****************************************
	// Stall cost
	// ****************************************
	wire pre_slow = is_pre & (~hit | ~op_imm_sel_i);
	wire base_slow = pre_slow | (is_br & gen);
	wire raw_i = reg_hit(wr_addr_prev_ff, `DAGMC_IDX_BASE, op_idx_i);
	wire raw_m = ~op_imm_sel_i & reg_hit(wr_addr_prev_ff, `DAGMC_MOD_BASE, mod_sel);
	wire raw_bl = reg_hit(wr_addr_prev_ff, `DAGMC_BUF_BASE, op_idx_i) |
		reg_hit(wr_addr_prev_ff, `DAGMC_LEN_BASE, op_idx_i);
	wire raw_haz = wr_prev_ff & (raw_i | raw_m | raw_bl);
	wire annul_haz = annul_ff & (annul_idx_ff == op_idx_i);
	wire [1:0] cost = {1'b0, base_slow} + {1'b0, raw_haz | annul_haz};
	wire emits = ~op_cond_false_i & (is_pre | is_post | is_br);

	// ****************************************
	// Address output and stall sequencing
	// ****************************************
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_ff <= 2'h0;
			emit_ff <= 1'b0;
			pend_addr_ff <= 32'h00000000;
			addr_o <= 32'h00000000;
			addr_valid_o <= 1'b0;
			stall_o <= 1'b0;
			annul_ff <= 1'b0;
			annul_idx_ff <= 4'h0;
		end else begin
			addr_valid_o <= 1'b0;
			// Remember an annulled post-modify for an operation in the next cycle
			annul_ff <= accept & op_cond_false_i & is_post;
			annul_idx_ff <= op_idx_i;
			// New operation: emit now or start the stall count
			if (accept) begin
				if (cost == 2'h0) begin
					addr_valid_o <= emits;
					addr_o <= out_addr;
					stall_o <= 1'b0;
				end else begin
					stall_o <= 1'b1;
				end
				cnt_ff <= cost;
				emit_ff <= emits;
				pend_addr_ff <= out_addr;
			end else if (cnt_ff != 2'h0) begin
				cnt_ff <= cnt_ff - 2'h1;
				// Last stall cycle releases the held address
				if (cnt_ff == 2'h1) begin
					addr_valid_o <= emit_ff;
					addr_o <= pend_addr_ff;
					stall_o <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Register file and write tracking
	// ****************************************
	integer n;
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (n = 0; n < 16; n = n + 1) begin
				idx_mem[n] <= 32'h00000000;
				mod_mem[n] <= 32'h00000000;
				base_mem[n] <= 32'h00000000;
				len_mem[n] <= 32'h00000000;
			end
			mode_ff <= `DAGMC_MODE_RST;
			wr_prev_ff <= 1'b0;
			wr_addr_prev_ff <= 7'h00;
		end else begin
			// Last bus write, for the read-after-write check
			wr_prev_ff <= reg_wr_i;
			wr_addr_prev_ff <= reg_addr_i;
			// Bus writes by bank
			if (reg_wr_i) begin
				case (reg_addr_i[6:4])
					3'h0: idx_mem[reg_addr_i[3:0]] <= reg_wdata_i;
					3'h1: mod_mem[reg_addr_i[3:0]] <= reg_wdata_i;
					3'h2: begin
						base_mem[reg_addr_i[3:0]] <= reg_wdata_i;
						idx_mem[reg_addr_i[3:0]] <= reg_wdata_i; // Base load also loads index
					end
					3'h3: len_mem[reg_addr_i[3:0]] <= reg_wdata_i;
					default: begin
						if (reg_addr_i == `DAGMC_MODE_ADDR) begin
							mode_ff <= reg_wdata_i;
						end
					end
				endcase
			end
			// Operation update wins over a same-cycle bus write
			if (upd_we) begin
				idx_mem[op_idx_i] <= new_idx;
			end
		end
	end

	// Sticky overflow flags: set wins, write one clears
	wire stky_wr = reg_wr_i & (reg_addr_i == `DAGMC_STKY_ADDR);
	wire [1:0] stky_set = {ovf_ev & gen, ovf_ev & ~gen};
	wire [1:0] stky_clr = stky_wr ? reg_wdata_i[1:0] : 2'h0;
	wire [1:0] nxt_stky = (stky_ff & ~stky_clr) | stky_set;
	wire [1:0] irq_mask = {mode_ff[`DAGMC_MASK_GEN2_BIT], mode_ff[`DAGMC_MASK_GEN1_BIT]};
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			stky_ff <= `DAGMC_STKY_RST;
			ovf_irq_o <= 1'b0;
		end else begin
			stky_ff <= nxt_stky;
			ovf_irq_o <= |(nxt_stky & irq_mask);
		end
	end

	// ****************************************
	// Index cache, one entry per generator
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gen_cache
			reg [2:0] idx_ff;
			reg [31:0] val_ff;
			reg vld_ff;
			wire mine = gen == g;
			wire [3:0] cfull = {(g == 1), idx_ff};
			// Bus write to the cached index, directly or through its base
			wire bus_hit = bus_idx_wr(reg_wr_i, reg_addr_i, cfull);
			// Operation write-back to the cached index
			wire upd_hit = upd_we & (op_idx_i == cfull);
			wire inv = bus_hit | upd_hit;
			// Refill on a miss, but a locked entry takes only its own index
			wire take = do_op & is_pre & mine & ~hit &
				(~lock | idx_ff == op_idx_i[2:0]);
			// Export the entry to the shared lookup
			assign cache_idx[g] = idx_ff;
			assign cache_val[g] = val_ff;
			assign cache_vld[g] = vld_ff;
			always @(posedge clk_i) begin
				if (sys_rst_i) begin
					idx_ff <= 3'h0;
					val_ff <= 32'h00000000;
					vld_ff <= 1'b0;
				end else if (take) begin
					idx_ff <= op_idx_i[2:0];
					val_ff <= i_val;
					// Same-cycle bus write to that index leaves the copy stale
					vld_ff <= ~bus_idx_wr(reg_wr_i, reg_addr_i, op_idx_i);
				end else if (inv) begin
					vld_ff <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// Register read port
	// ****************************************
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			case (reg_addr_i[6:4])
				3'h0: reg_rdata_o <= idx_mem[reg_addr_i[3:0]];
				3'h1: reg_rdata_o <= mod_mem[reg_addr_i[3:0]];
				3'h2: reg_rdata_o <= base_mem[reg_addr_i[3:0]];
				3'h3: reg_rdata_o <= len_mem[reg_addr_i[3:0]];
				default: begin
					if (reg_addr_i == `DAGMC_MODE_ADDR) begin
						reg_rdata_o <= mode_ff;
					end else if (reg_addr_i == `DAGMC_STKY_ADDR) begin
						reg_rdata_o <= {30'h0, stky_ff};
					end else begin
						reg_rdata_o <= 32'h00000000;
					end
				end
			endcase
		end
	end

endmodule

// ===== testbench/dagmc_core_props.sv
// Port checks for the address generator
module dagmc_core_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [6:0] reg_addr_i,
	input wire logic reg_wr_i,
	// Operation and answer
	input wire logic op_valid_i,
	input wire logic [2:0] op_kind_i,
	input wire logic [3:0] op_idx_i,
	input wire logic op_imm_sel_i,
	input wire logic op_cond_false_i,
	input wire logic addr_valid_o,
	input wire logic stall_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Operation accepted this cycle
	wire logic take = op_valid_i && !stall_o;
	property p_pre_mreg;
		take && op_kind_i == 3'h0 && !op_imm_sel_i && !op_cond_false_i && !$past(reg_wr_i)
			&& !$past(op_valid_i) |=> stall_o ##1 !stall_o && addr_valid_o;
	endproperty
	a_pre_mreg: assert property (p_pre_mreg) else $error("register pre-modify not 2 cycles");
	property p_br2;
		take && op_kind_i == 3'h4 && op_idx_i[3] && !op_cond_false_i && !$past(reg_wr_i)
			&& !$past(op_valid_i) |=> stall_o ##1 !stall_o && addr_valid_o;
	endproperty
	a_br2: assert property (p_br2) else $error("branch in second unit not 2 cycles");
	property p_stall_gap;
		stall_o |-> !addr_valid_o;
	endproperty
	a_stall_gap: assert property (p_stall_gap) else $error("address during stall");
	property p_stall_max;
		$rose(stall_o) |-> ##[1:2] !stall_o;
	endproperty
	a_stall_max: assert property (p_stall_max) else $error("stall too long");
	property p_noaddr;
		take && (op_kind_i == 3'h2 || op_kind_i == 3'h3) |=> !addr_valid_o;
	endproperty
	a_noaddr: assert property (p_noaddr) else $error("address from modify op");
	property p_annul;
		take && op_cond_false_i |=> !addr_valid_o;
	endproperty
	a_annul: assert property (p_annul) else $error("address from annulled op");
	property p_haz;
		take && $past(reg_wr_i) && $past(reg_addr_i) == {3'h0, op_idx_i} |=> stall_o;
	endproperty
	a_haz: assert property (p_haz) else $error("no stall after index write");
	property p_cause;
		addr_valid_o |-> $past(take) || $fell(stall_o);
	endproperty
	a_cause: assert property (p_cause) else $error("address without operation");
endmodule

// ===== testbench/dagmc_mem_model.sv
// Data memory stand-in that counts address strobes
module dagmc_mem_model (
	// Clock and address
	input wire logic clk_i,
	input wire logic [31:0] addr_i,
	input wire logic valid_i,
	// Observed traffic
	output logic [31:0] last_o,
	output logic [31:0] cnt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] seen = 32'h0;
	assign cnt_o = seen;
	// Latch each presented address
	always @(posedge clk_i) begin
		if (valid_i === 1'b1) begin
			last_o <= addr_i;
			seen <= seen + 32'h1;
		end
	end
endmodule

// ===== testbench/tb_data_address_generator_modify_cache.sv
// Directed test of the address generator
module tb_data_address_generator_modify_cache;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [2:0] PRE = 3'h0, POST = 3'h1, MDF = 3'h2, BRV = 3'h3, BRA = 3'h4;
	localparam [3:0] IM = 4'h1, MU = 4'h2, CF = 4'h4, HZ = 4'h8;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [6:0] reg_addr_i = 7'h00;
	logic [31:0] reg_wdata_i = 32'h0, op_imm_i = 32'h0;
	logic op_valid_i = 1'b0, op_imm_sel_i = 1'b0, op_multi_i = 1'b0, op_cond_false_i = 1'b0;
	logic [2:0] op_kind_i = 3'h0, op_mod_i = 3'h0;
	logic [3:0] op_idx_i = 4'h0;
	logic [1:0] op_size_i = 2'h1;
	logic [31:0] reg_rdata_o, addr_o, last, cnt;
	logic addr_valid_o, stall_o, ovf_irq_o;
	int n_errors = 0, comparisons = 0, n_acc = 0;
	dagmc_core dagmc_core_i (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .op_valid_i, .op_kind_i, .op_idx_i, .op_mod_i, .op_imm_sel_i,
		.op_multi_i, .op_imm_i, .op_size_i, .op_cond_false_i, .addr_o, .addr_valid_o,
		.stall_o, .ovf_irq_o);
	dagmc_mem_model dagmc_mem_model_i (.clk_i, .addr_i(addr_o), .valid_i(addr_valid_o),
		.last_o(last), .cnt_o(cnt));
	// Clock
	initial forever #50 clk_i = ~clk_i;
	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("rdata", reg_rdata_o, e);
	endtask
	// Issue one operation, count stall cycles, check address
	task automatic op(input logic [2:0] k, input logic [3:0] i, input logic [2:0] m,
		input logic [31:0] imm, input logic [3:0] f, input int ec, input logic [31:0] ea);
		int n;
		logic ev;
		ev = (k == PRE || k == POST || k == BRA) && !f[2];
		if (!f[3]) @(posedge clk_i);
		op_valid_i <= 1'b1;
		op_kind_i <= k;
		op_idx_i <= i;
		op_mod_i <= m;
		op_imm_i <= imm;
		{op_cond_false_i, op_multi_i, op_imm_sel_i} <= f[2:0];
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		#1;
		n = 0;
		while (stall_o === 1'b1 && n < 4) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (ev) n_acc++;
		chk("cost", n, ec);
		chk("valid", addr_valid_o, ev);
		if (ev) chk("addr", addr_o, ea);
	endtask
	task automatic close_out();
		if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#300000;
		n_errors++;
		close_out();
	end
	// Test sequence
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(7'h41, 32'h0);
		rd(7'h7F, 32'h0);
		wr(7'h01, 32'h100);
		wr(7'h11, 32'h10);
		wr(7'h19, 32'h20);
		wr(7'h09, 32'h300);
		wr(7'h02, 32'h400);
		op(PRE, 1, 0, 32'h10, IM, 1, 32'h110);
		op(PRE, 1, 0, 32'h10, IM, 0, 32'h110);
		op(PRE, 1, 1, 32'h0, 4'h0, 1, 32'h110);
		op(PRE, 1, 0, 32'h4, IM, 0, 32'h104);
		op(PRE, 9, 1, 32'h0, 4'h0, 1, 32'h320);
		op(PRE, 2, 0, 32'h0, IM, 1, 32'h400);
		rd(7'h02, 32'h400);
		op(PRE, 1, 0, 32'h0, IM, 1, 32'h100);
		op(POST, 1, 1, 32'h0, 4'h0, 0, 32'h100);
		rd(7'h01, 32'h110);
		op(PRE, 1, 0, 32'h0, IM, 1, 32'h110);
		wr(7'h40, 32'h10000);
		op(PRE, 2, 0, 32'h0, IM, 1, 32'h400);
		op(PRE, 1, 0, 32'h0, IM, 0, 32'h110);
		wr(7'h01, 32'h200);
		op(PRE, 1, 0, 32'h0, IM, 1, 32'h200);
		op(PRE, 1, 0, 32'h0, IM, 0, 32'h200);
		wr(7'h03, 32'h500);
		op(POST, 3, 0, 32'h0, IM | HZ, 1, 32'h500);
		@(posedge clk_i);
		op_size_i <= 2'h0;
		op(POST, 3, 0, 32'h0, IM, 0, 32'hA00);
		op_size_i <= 2'h2;
		op(POST, 3, 0, 32'h0, IM, 0, 32'h280);
		op_size_i <= 2'h1;
		op(POST, 4, 0, 32'h12345678, IM, 0, 32'h0);
		rd(7'h04, 32'h12345678);
		op(POST, 4, 0, 32'h1FFF, IM | MU, 0, 32'h12345678);
		rd(7'h04, 32'h12345677);
		wr(7'h00, 32'h83000);
		wr(7'h10, 32'h4000000);
		wr(7'h40, 32'h2);
		op(POST, 0, 0, 32'h0, 4'h0, 0, 32'hC1000);
		rd(7'h00, 32'h4083000);
		wr(7'h05, 32'h1);
		op(BRV, 5, 0, 32'h0, 4'h0, 0, 32'h0);
		rd(7'h05, 32'h80000000);
		wr(7'h40, 32'h01040000);
		wr(7'h27, 32'h100);
		wr(7'h37, 32'h10);
		op(POST, 7, 0, 32'h8, IM, 0, 32'h100);
		op(POST, 7, 0, 32'h8, IM, 0, 32'h108);
		rd(7'h07, 32'h100);
		rd(7'h41, 32'h1);
		chk("irq", ovf_irq_o, 1'b1);
		op(MDF, 7, 0, 32'h8, IM, 0, 32'h0);
		rd(7'h41, 32'h1);
		wr(7'h40, 32'h01000000);
		rd(7'h07, 32'h108);
		chk("irq", ovf_irq_o, 1'b0);
		wr(7'h41, 32'h1);
		rd(7'h41, 32'h0);
		op(BRA, 8, 0, 32'h0, IM, 1, 32'h0);
		op(PRE, 9, 0, 32'h0, IM, 0, 32'h300);
		wr(7'h40, 32'h1);
		wr(7'h08, 32'h83000);
		op(PRE, 8, 0, 32'h0, IM, 1, 32'hC1000);
		op(POST, 1, 0, 32'h4, IM | CF, 0, 32'h0);
		op(POST, 1, 0, 32'h0, IM | HZ, 1, 32'h200);
		@(posedge clk_i);
		#1;
		chk("accesses", cnt, n_acc);
		chk("last", last, 32'h200);
		close_out();
	end
endmodule
bind dagmc_core dagmc_core_props dagmc_core_props_i (.clk_i, .sys_rst_i, .reg_addr_i,
	.reg_wr_i, .op_valid_i, .op_kind_i, .op_idx_i, .op_imm_sel_i, .op_cond_false_i,
	.addr_valid_o, .stall_o);
